/* File: sim/mfap_adv_page_test.sv */
// self-checking bench for the feature advertising page
`timescale 1ns/1ps
module mfap_adv_page_test;
  import mfap_pkg::*;
  logic i_core_clk, i_rst;
  logic [7:0] host_addr, host_wdata, host_rdata;
  logic host_rd, host_wr, rd_valid, wr_ign, page_ready;
  logic diag, user, bank2, cooled, avalanche_detector, pavg, losavg, losfast, txfast, wide;
  logic [1:0] grp, eqt;
  logic [2:0] aux, rxc;
  logic [15:0] wait_us;
  logic [LANES-1:0][21:0] bring, tear;
  logic [21:0] pdown;
  logic [7:0] tmax, tmin, txc;
  logic [19:0] dly;
  logic [12:0] volt;
  logic [11:0] byp;
  logic [3:0] amp, txeq, post, pre, txf;
  logic [LANES-1:0] dis, tx_off;
  logic sel_n, start, done, sel_early, rel_early;
  int exp_b [16];
  int seed = 8314;
  int fail_count = 0;
  int n_compared = 0;

  mfap_adv_page mfap_adv_page_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_host_addr(host_addr), .i_host_rd(host_rd), .i_host_wr(host_wr),
    .i_host_wdata(host_wdata), .o_host_rdata(host_rdata),
    .o_host_rd_valid(rd_valid), .o_write_ignored(wr_ign),
    .o_page_ready(page_ready), .i_diag_pages(diag), .i_user_page(user),
    .i_second_bank(bank2), .i_select_wait_us(wait_us),
    .i_bringup_ms(bring), .i_teardown_ms(tear), .i_power_down_ms(pdown),
    .i_cooled(cooled), .i_tx_grouping(grp), .i_aux_types(aux),
    .i_temp_max(tmax), .i_temp_min(tmin), .i_cable_delay_ns(dly),
    .i_min_voltage_mv(volt), .i_avalanche_detector(avalanche_detector),
    .i_rx_eq_type(eqt), .i_rx_power_avg(pavg), .i_los_avg(losavg),
    .i_los_fast(losfast), .i_txdis_fast(txfast),
    .i_module_wide_txdis(wide), .i_bypass_saving_mw(byp),
    .i_amp_codes(amp), .i_max_tx_eq(txeq), .i_max_rx_post(post),
    .i_max_rx_pre(pre), .i_tx_controls(txc), .i_rx_controls(rxc),
    .i_tx_flags(txf), .i_lane_tx_disable(dis), .o_lane_tx_off(tx_off),
    .i_module_select_n(sel_n), .i_bus_start(start), .i_bus_done(done),
    .o_select_early(sel_early), .o_release_early(rel_early));

  mfap_host_model mfap_host_model_i (.i_core_clk(i_core_clk),
    .i_rdata(host_rdata), .i_rd_valid(rd_valid), .i_wr_ignored(wr_ign),
    .i_select_early(sel_early), .i_release_early(rel_early),
    .o_addr(host_addr), .o_rd(host_rd), .o_wr(host_wr),
    .o_wdata(host_wdata), .o_select_n(sel_n), .o_bus_start(start),
    .o_bus_done(done));

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  function automatic int lim(input int k);
    int t [14] = '{0, 1, 5, 10, 50, 100, 500, 1000, 5000, 10000, 60000,
      300000, 600000, 3000000};
    return t[k];
  endfunction : lim

  // code is the count of lower bounds reached
  function automatic int dcode(input int ms);
    int c = 0;
    for (int k = 1; k < 14; k++) if (ms >= lim(k)) c = k;
    return c;
  endfunction : dcode

  function automatic int cdiv(input int a, input int b, input int top);
    int q = (a + b - 1) / b;
    return (q > top) ? top : q;
  endfunction : cdiv

  // smallest exponent whose rounded-up mantissa fits five bits
  function automatic int wcode(input int us);
    for (int e = 0; e < 8; e++) begin
      if (((us + (1 << e) - 1) >> e) <= 31) return e * 32 + cdiv(us, 1 << e, 31);
    end
    return 255;
  endfunction : wcode

  // small values as often as large ones
  function automatic logic [31:0] rnd();
    logic [31:0] v;
    v = $random(seed);
    return v >> v[31:27];
  endfunction : rnd

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic setcfg(input int k);
    @(posedge i_core_clk);
    {diag, user, bank2, cooled, grp, aux, avalanche_detector, eqt} <= 12'($random(seed));
    {pavg, losavg, losfast, txfast, wide} <= 5'($random(seed));
    {tmax, tmin, amp, txeq, post, pre} <= $random(seed);
    {txc, rxc, txf} <= 15'($random(seed));
    wait_us <= (k == 0) ? 16'h0003 : (k == 1) ? 16'h0F81 : 16'(rnd());
    dly <= 20'(rnd());
    volt <= 13'(rnd());
    byp <= 12'(rnd());
    pdown <= 22'(rnd());
    // one lane on the code boundary, the others just below it
    for (int l = 0; l < LANES; l++) begin
      bring[l] <= 22'((l == k % LANES) ? lim(k) : (k > 0 ? lim(k) - 1 : 0));
      tear[l] <= 22'(rnd());
    end
  endtask : setcfg

  task automatic model_bytes();
    int bm;
    int tm;
    int dl;
    bm = 0;
    tm = int'(pdown);
    for (int l = 0; l < LANES; l++) begin
      if (int'(bring[l]) > bm) bm = int'(bring[l]);
      if (int'(tear[l]) > tm) tm = int'(tear[l]);
    end
    dl = (int'(dly) + 5) / 10;
    if (dl > 65535) dl = 65535;
    exp_b[0] = diag * 32 + user * 4 + bank2;
    exp_b[1] = wcode(int'(wait_us));
    // teardown or power-down high, bring-up low
    exp_b[2] = dcode(tm) * 16 + dcode(bm);
    exp_b[3] = cooled * 128 + grp * 32 + aux;
    exp_b[4] = tmax;
    exp_b[5] = tmin;
    exp_b[6] = dl / 256;
    exp_b[7] = dl % 256;
    exp_b[8] = cdiv(int'(volt), 20, 255);
    // reserved equalizer code reads as zero
    exp_b[9] = avalanche_detector * 128 + (eqt == 2'h3 ? 0 : eqt) * 32 + pavg * 16;
    exp_b[9] += losavg * 8 + losfast * 4 + txfast * 2 + wide;
    exp_b[10] = cdiv(int'(byp), 10, 255);
    exp_b[11] = amp * 16 + txeq;
    exp_b[12] = post * 16 + pre;
    exp_b[13] = txc;
    exp_b[14] = rxc;
    exp_b[15] = txf;
  endtask : model_bytes

  task automatic rdexp(input int a, output logic [7:0] d,
      output logic [7:0] e);
    logic v;
    logic ig;
    mfap_host_model_i.access(8'(8'h8E + a), 1'b0, 8'h00, d, v, ig);
    e = 8'(exp_b[a]);
  endtask : rdexp

  initial begin
    logic [7:0] d;
    logic [7:0] e;
    logic v;
    logic ig;
    logic f1;
    logic f2;
    int n;
    {diag, user, bank2, cooled, grp, aux, avalanche_detector, eqt, pavg, losavg} = '0;
    {losfast, txfast, wide, tmax, tmin, amp, txeq, post, pre} = '0;
    {txc, rxc, txf, wait_us, dly, volt, byp, pdown, dis} = '0;
    bring = '0;
    tear = '0;
    i_rst = 1'b1;
    for (int k = 0; k < 14; k++) begin
      setcfg(k);
      i_rst <= 1'b1;
      repeat (5) @(posedge i_core_clk);
      i_rst <= 1'b0;
      model_bytes();
      // bounded wait for the page, a hang counts as a fault
      n = 0;
      while (page_ready !== 1'b1 && n < 40) begin
        @(posedge i_core_clk);
        n++;
      end
      if (page_ready !== 1'b1) begin
        fail_count++;
        results();
      end
      for (int a = 0; a < 3; a++) begin
        rdexp(a, d, e);
        check(d, e);
      end
      for (int a = 3; a < 9; a++) begin
        rdexp(a, d, e);
        check(d, e);
      end
      for (int a = 9; a < 16; a++) begin
        rdexp(a, d, e);
        check(d, e);
      end
      mfap_host_model_i.access(OFF_TX_CTRL, 1'b1, ~8'(exp_b[13]), d, v, ig);
      check(8'(ig), 8'h01);
      rdexp(13, d, e);
      check(d, e);
      mfap_host_model_i.access(8'h9E, 1'b1, 8'h5A, d, v, ig);
      check(8'(ig), 8'h00);
      mfap_host_model_i.access(8'h9E, 1'b0, 8'h00, d, v, ig);
      check(d, 8'h00);
      check(8'(v), 8'h01);
      for (int j = 0; j < 3; j++) begin
        @(posedge i_core_clk);
        dis <= (j == 2) ? 8'h00 : 8'($random(seed));
        @(posedge i_core_clk);
        #1;
        check(tx_off, (wide && dis != 8'h00) ? 8'hFF : dis);
      end
      if (k == 0) begin
        mfap_host_model_i.txn(40, 100, f1, f2);
        check(8'({f1, f2}), 8'h02);
        mfap_host_model_i.txn(100, 40, f1, f2);
        check(8'({f1, f2}), 8'h01);
        mfap_host_model_i.txn(0, 100, f1, f2);
        check(8'({f1, f2}), 8'h02);
      end
      $display("config %0d done", k);
    end
    results();
  end
endmodule : mfap_adv_page_test

/* File: sim/mfap_host_model.sv */
// host controller model: byte accesses and select framing
`timescale 1ns/1ps
module mfap_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rd_valid,
  input wire logic i_wr_ignored,
  input wire logic i_select_early,
  input wire logic i_release_early,
  output logic [7:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_select_n,
  output logic o_bus_start,
  output logic o_bus_done
);
  logic saw_early;
  logic saw_late;

  initial begin
    {o_addr, o_rd, o_wr, o_wdata, o_bus_start, o_bus_done} = '0;
    o_select_n = 1'b1;
    saw_early = 1'b0;
    saw_late = 1'b0;
  end

  // pulses are one cycle wide, so keep them until the caller asks
  always @(posedge i_core_clk) begin
    if (i_select_early === 1'b1) saw_early <= 1'b1;
    if (i_release_early === 1'b1) saw_late <= 1'b1;
  end

  // released address and data lines show the inverse of the last value, not a stale copy
  task automatic access(input logic [7:0] addr, input logic wr,
      input logic [7:0] wdata, output logic [7:0] rdata,
      output logic valid, output logic ignored);
    @(posedge i_core_clk);
    o_addr <= addr;
    o_rd <= ~wr;
    o_wr <= wr;
    o_wdata <= wdata;
    @(posedge i_core_clk);
    o_addr <= ~addr;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_wdata <= ~wdata;
    #1;
    rdata = i_rdata;
    valid = i_rd_valid;
    ignored = i_wr_ignored;
  endtask : access

  task automatic txn(input int lead, input int trail, output logic early,
      output logic late);
    @(posedge i_core_clk);
    saw_early = 1'b0;
    saw_late = 1'b0;
    o_select_n <= 1'b0;
    repeat (lead) @(posedge i_core_clk);
    o_bus_start <= 1'b1;
    @(posedge i_core_clk);
    o_bus_start <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    o_bus_done <= 1'b1;
    @(posedge i_core_clk);
    o_bus_done <= 1'b0;
    repeat (trail) @(posedge i_core_clk);
    o_select_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    #1;
    early = saw_early;
    late = saw_late;
  endtask : txn
endmodule : mfap_host_model

/* File: src/mfap_adv_mem.sv */
// sixteen-byte store of the advertising page, registered read
`timescale 1ns/1ps
module mfap_adv_mem (
  input wire logic i_core_clk,
  input wire logic i_rst,
  mfap_mem_if.store m
);
  import mfap_pkg::*;
  logic [7:0] arr [16];
  always_ff @(posedge i_core_clk) begin
    if (m.we) begin
      arr[m.waddr] <= m.wdata;
    end
  end
  // a miss answers zero so the host never sees stale data
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      m.rdata <= RDATA_RST;
    end else if (m.re) begin
      m.rdata <= m.rhit ? arr[m.raddr] : RDATA_RST;
    end
  end
endmodule : mfap_adv_mem

/* File: src/mfap_adv_page.sv */
// feature advertising page: byte store, loader, host reads
`timescale 1ns/1ps
module mfap_adv_page (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_host_addr,
  input wire logic i_host_rd,
  input wire logic i_host_wr,
  input wire logic [7:0] i_host_wdata,
  output logic [7:0] o_host_rdata,
  output logic o_host_rd_valid,
  output logic o_write_ignored,
  output logic o_page_ready,
  input wire logic i_diag_pages,
  input wire logic i_user_page,
  input wire logic i_second_bank,
  input wire logic [15:0] i_select_wait_us,
  input wire logic [mfap_pkg::LANES-1:0][21:0] i_bringup_ms,
  input wire logic [mfap_pkg::LANES-1:0][21:0] i_teardown_ms,
  input wire logic [21:0] i_power_down_ms,
  input wire logic i_cooled,
  input wire logic [1:0] i_tx_grouping,
  input wire logic [2:0] i_aux_types,
  input wire logic [7:0] i_temp_max,
  input wire logic [7:0] i_temp_min,
  input wire logic [19:0] i_cable_delay_ns,
  input wire logic [12:0] i_min_voltage_mv,
  input wire logic i_avalanche_detector,
  input wire logic [1:0] i_rx_eq_type,
  input wire logic i_rx_power_avg,
  input wire logic i_los_avg,
  input wire logic i_los_fast,
  input wire logic i_txdis_fast,
  input wire logic i_module_wide_txdis,
  input wire logic [11:0] i_bypass_saving_mw,
  input wire logic [3:0] i_amp_codes,
  input wire logic [3:0] i_max_tx_eq,
  input wire logic [3:0] i_max_rx_post,
  input wire logic [3:0] i_max_rx_pre,
  input wire logic [7:0] i_tx_controls,
  input wire logic [2:0] i_rx_controls,
  input wire logic [3:0] i_tx_flags,
  input wire logic [mfap_pkg::LANES-1:0] i_lane_tx_disable,
  output logic [mfap_pkg::LANES-1:0] o_lane_tx_off,
  input wire logic i_module_select_n,
  input wire logic i_bus_start,
  input wire logic i_bus_done,
  output logic o_select_early,
  output logic o_release_early
);
  import mfap_pkg::*;

  mfap_mem_if mif ();
  mfap_load_type ld_r;
  logic [3:0] idx_r;
  logic [7:0] wait_code;
  logic [7:0] adv [16];

  mfap_wait_enc u_wait_enc (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_wait_us(i_select_wait_us),
    .o_code(wait_code)
  );

  mfap_adv_mem u_adv_mem (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .m(mif)
  );

  // worst case over all data paths
  logic [21:0] up_max [LANES+1];
  logic [21:0] down_max [LANES+1];
  logic [21:0] down_worst;
  logic [7:0] dur_r;
  assign up_max[0] = 22'h000000;
  assign down_max[0] = 22'h000000;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_worst
      assign up_max[g+1] = (i_bringup_ms[g] > up_max[g]) ?
                           i_bringup_ms[g] : up_max[g];
      assign down_max[g+1] = (i_teardown_ms[g] > down_max[g]) ?
                             i_teardown_ms[g] : down_max[g];
    end
  endgenerate
  assign down_worst = (i_power_down_ms > down_max[LANES]) ?
                      i_power_down_ms : down_max[LANES];

  // conversions are registered so the loader sees settled values
  logic [20:0] delay_units;
  logic [13:0] volt_steps;
  logic [12:0] power_steps;
  logic [15:0] delay_r;
  logic [7:0] volt_r;
  logic [7:0] power_r;
  assign delay_units = (21'(i_cable_delay_ns) + 21'(DELAY_UNIT_NS / 2))
                       / 21'(DELAY_UNIT_NS);
  assign volt_steps = (14'(i_min_voltage_mv) + 14'(VOLT_STEP_MV - 1))
                      / 14'(VOLT_STEP_MV);
  assign power_steps = (13'(i_bypass_saving_mw) + 13'(POWER_STEP_MW - 1))
                       / 13'(POWER_STEP_MW);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      delay_r <= 16'h0000;
      volt_r <= 8'h00;
      power_r <= 8'h00;
      dur_r <= 8'h00;
    end else begin
      // saturation keeps an oversized figure from wrapping small
      delay_r <= (delay_units > 21'h00FFFF) ? 16'hFFFF : delay_units[15:0];
      volt_r <= (volt_steps > 14'h00FF) ? 8'hFF : volt_steps[7:0];
      power_r <= (power_steps > 13'h00FF) ? 8'hFF : power_steps[7:0];
      dur_r <= {mfap_dur_code(down_worst), mfap_dur_code(up_max[LANES])};
    end
  end

  logic [1:0] rx_eq;
  // reserved equalizer code falls back to peak
  assign rx_eq = (i_rx_eq_type == RX_EQ_RSVD) ? RX_EQ_PEAK : i_rx_eq_type;

  // only codes 00b and 01b are produced
  assign adv[0] = {2'b00, i_diag_pages, 2'b00, i_user_page,
                   i_second_bank ? BANKS_ZERO_ONE : BANKS_ZERO};
  assign adv[1] = wait_code;
  assign adv[2] = dur_r;
  assign adv[3] = {i_cooled, i_tx_grouping, 2'b00, i_aux_types};
  assign adv[4] = i_temp_max;
  assign adv[5] = i_temp_min;
  assign adv[6] = delay_r[15:8];
  assign adv[7] = delay_r[7:0];
  assign adv[8] = volt_r;
  assign adv[9] = {i_avalanche_detector, rx_eq, i_rx_power_avg,
                   i_los_avg, i_los_fast, i_txdis_fast,
                   i_module_wide_txdis};
  assign adv[10] = power_r;
  // bit 7 is code 0011b down to bit 4 for 0000b
  assign adv[11] = {i_amp_codes, i_max_tx_eq};
  assign adv[12] = {i_max_rx_post, i_max_rx_pre};
  assign adv[13] = i_tx_controls;
  assign adv[14] = {5'b00000, i_rx_controls};
  assign adv[15] = {4'h0, i_tx_flags};

  // loader: one idle cycle lets conversions settle, then 16 writes
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ld_r <= LD_IDLE;
    end else begin
      case (ld_r)
        LD_IDLE: begin
          ld_r <= LD_FILL;
        end
        LD_FILL: begin
          if (idx_r == LAST_INDEX) begin
            ld_r <= LD_READY;
          end
        end
        LD_READY: begin
          ld_r <= LD_READY;
        end
        default: begin
          ld_r <= LD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      idx_r <= 4'h0;
    end else if (ld_r == LD_FILL) begin
      idx_r <= idx_r + 4'h1;
    end
  end

  // host writes never reach the store
  assign mif.we = (ld_r == LD_FILL);
  assign mif.waddr = idx_r;
  assign mif.wdata = adv[idx_r];

  function automatic logic addr_hit(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a < OFF_PAGE_BANK) begin
      hit = 1'b0;
    end else if (a > OFF_TX_FLAGS) begin
      hit = 1'b0;
    end else begin
      hit = 1'b1;
    end
    return hit;
  endfunction : addr_hit

  logic [7:0] rel_addr;
  assign rel_addr = i_host_addr - OFF_PAGE_BANK;
  assign mif.re = i_host_rd;
  assign mif.rhit = addr_hit(i_host_addr) && (ld_r == LD_READY);
  assign mif.raddr = rel_addr[3:0];
  assign o_host_rdata = mif.rdata;
  assign o_page_ready = (ld_r == LD_READY);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_rd_valid <= 1'b0;
      o_write_ignored <= 1'b0;
    end else begin
      o_host_rd_valid <= i_host_rd;
      // a write inside the page is dropped and only reported; a write elsewhere is dropped silently
      o_write_ignored <= i_host_wr && addr_hit(i_host_addr);
    end
  end

  // one set bit disables every lane when module wide
  // per-lane mode leaves other lanes running
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lane_tx_off <= '0;
    end else if (i_module_wide_txdis && |i_lane_tx_disable) begin
      o_lane_tx_off <= '1;
    end else begin
      o_lane_tx_off <= i_lane_tx_disable;
    end
  end

  // select wait supervision, in core cycles
  logic [11:0] wait_us;
  logic [16:0] wait_cyc;
  logic [16:0] sel_cnt_r;
  logic [16:0] post_cnt_r;
  logic post_pend_r;
  logic sel_prev_r;
  assign wait_us = 12'(wait_code[4:0]) << wait_code[7:5];
  assign wait_cyc = 17'(wait_us) * 17'(CYC_PER_US);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_cnt_r <= 17'h00000;
    end else if (i_module_select_n) begin
      sel_cnt_r <= 17'h00000;
    end else if (sel_cnt_r != 17'h1FFFF) begin
      sel_cnt_r <= sel_cnt_r + 17'h00001;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      post_cnt_r <= 17'h00000;
      post_pend_r <= 1'b0;
    end else if (i_module_select_n || i_bus_start) begin
      post_cnt_r <= 17'h00000;
      post_pend_r <= 1'b0;
    end else if (i_bus_done) begin
      post_cnt_r <= 17'h00000;
      post_pend_r <= 1'b1;
    end else if (post_pend_r && post_cnt_r != 17'h1FFFF) begin
      post_cnt_r <= post_cnt_r + 17'h00001;
    end
  end

  // the flags only report; the bus engine decides what to do
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_prev_r <= 1'b1;
      o_select_early <= 1'b0;
      o_release_early <= 1'b0;
    end else begin
      sel_prev_r <= i_module_select_n;
      // start before the setup wait elapsed
      o_select_early <= i_bus_start && !i_module_select_n &&
                        (sel_cnt_r < wait_cyc);
      // release before the hold wait elapsed
      o_release_early <= i_module_select_n && !sel_prev_r &&
                         post_pend_r && (post_cnt_r < wait_cyc);
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  chk_read_latency: assert property (
    i_host_rd |=> o_host_rd_valid ##1 (!o_host_rd_valid || $past(i_host_rd))
  ) else $error("read answer not one cycle after request");

  chk_bank_byte_fields: assert property (
    o_host_rd_valid && $past(i_host_addr) == OFF_PAGE_BANK &&
    $past(o_page_ready)
    |-> o_host_rdata[7:6] == 2'b00 && o_host_rdata[4:3] == 2'b00 &&
        o_host_rdata[1] == 1'b0
  ) else $error("bank byte reserved bits not zero");

  chk_duration_codes: assert property (
    o_host_rd_valid && $past(i_host_addr) == OFF_DURATION
    |-> o_host_rdata[7:4] <= DUR_CODE_MAX &&
        o_host_rdata[3:0] <= DUR_CODE_MAX
  ) else $error("reserved duration code advertised");

  chk_rx_eq_type: assert property (
    o_host_rd_valid && $past(i_host_addr) == OFF_RX_CHAR
    |-> o_host_rdata[6:5] != RX_EQ_RSVD
  ) else $error("reserved receive equalizer type advertised");

  chk_rx_ctrl_byte: assert property (
    o_host_rd_valid && $past(i_host_addr) == OFF_RX_CTRL
    |-> o_host_rdata[7:3] == 5'b00000
  ) else $error("receive control byte reserved bits set");

  chk_wide_disable: assert property (
    i_module_wide_txdis && |i_lane_tx_disable |=> o_lane_tx_off == '1
  ) else $error("module-wide disable left a lane running");

  chk_lane_disable: assert property (
    !i_module_wide_txdis |=> o_lane_tx_off == $past(i_lane_tx_disable)
  ) else $error("per-lane disable touched another lane");

  chk_select_early: assert property (
    i_bus_start && !i_module_select_n && sel_cnt_r == 17'h00000 &&
    wait_cyc != 17'h00000 |=> o_select_early
  ) else $error("early transaction start not flagged");

  chk_load_order: assert property (
    $rose(ld_r == LD_FILL) |-> (ld_r == LD_FILL) [*8] ##9 o_page_ready
  ) else $error("page not ready sixteen cycles after load start");

  chk_write_ignored: assert property (
    o_page_ready && i_host_wr && addr_hit(i_host_addr)
    |=> o_write_ignored && !mif.we && o_page_ready
  ) else $error("host write disturbed the store");
endmodule : mfap_adv_page

/* File: src/mfap_mem_if.sv */
// carrier between the loader and the advertising byte store
`timescale 1ns/1ps
interface mfap_mem_if;
  logic we;
  logic [3:0] waddr;
  logic [7:0] wdata;
  logic re;
  logic rhit;
  logic [3:0] raddr;
  logic [7:0] rdata;
  modport ctrl(output we, waddr, wdata, re, rhit, raddr, input rdata);
  modport store(input we, waddr, wdata, re, rhit, raddr, output rdata);
endinterface : mfap_mem_if

/* File: src/mfap_pkg.sv */
// constants, types and shared decoding for the feature advertising page
package mfap_pkg;
  localparam logic [7:0] OFF_PAGE_BANK = 8'h8E;
  localparam logic [7:0] OFF_SEL_WAIT = 8'h8F;
  localparam logic [7:0] OFF_DURATION = 8'h90;
  localparam logic [7:0] OFF_TX_CHAR = 8'h91;
  localparam logic [7:0] OFF_TEMP_MAX = 8'h92;
  localparam logic [7:0] OFF_TEMP_MIN = 8'h93;
  localparam logic [7:0] OFF_DELAY_HI = 8'h94;
  localparam logic [7:0] OFF_DELAY_LO = 8'h95;
  localparam logic [7:0] OFF_MIN_VOLT = 8'h96;
  localparam logic [7:0] OFF_RX_CHAR = 8'h97;
  localparam logic [7:0] OFF_BYPASS = 8'h98;
  localparam logic [7:0] OFF_AMP_TXEQ = 8'h99;
  localparam logic [7:0] OFF_RX_EQ = 8'h9A;
  localparam logic [7:0] OFF_TX_CTRL = 8'h9B;
  localparam logic [7:0] OFF_RX_CTRL = 8'h9C;
  localparam logic [7:0] OFF_TX_FLAGS = 8'h9D;
  localparam logic [3:0] LAST_INDEX = 4'hF;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] WAIT_CODE_MAX = 8'hFF;
  localparam logic [4:0] MANT_MAX = 5'h1F;
  localparam logic [1:0] BANKS_ZERO = 2'h0;
  localparam logic [1:0] BANKS_ZERO_ONE = 2'h1;
  localparam logic [1:0] RX_EQ_RSVD = 2'h3;
  localparam logic [1:0] RX_EQ_PEAK = 2'h0;
  localparam logic [3:0] DUR_CODE_MAX = 4'hD;
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int DELAY_UNIT_NS = 10;
  localparam int VOLT_STEP_MV = 20;
  localparam int POWER_STEP_MW = 10;
  localparam int LANES = 8;
  typedef enum logic [2:0] {
    LD_IDLE = 3'b001,
    LD_FILL = 3'b010,
    LD_READY = 3'b100
  } mfap_load_type;
  // lower bounds of codes 0001b..1101b, in ms
  localparam logic [21:0] DUR_LIMIT_MS [13] = '{
    22'h000001, 22'h000005, 22'h00000A, 22'h000032, 22'h000064,
    22'h0001F4, 22'h0003E8, 22'h001388, 22'h002710, 22'h00EA60,
    22'h0493E0, 22'h0927C0, 22'h2DC6C0};
  function automatic logic [3:0] mfap_dur_code(input logic [21:0] ms);
    logic [3:0] code;
    code = 4'h0;
    for (int i = 0; i < 13; i++) begin
      if (ms >= DUR_LIMIT_MS[i]) begin
        code = 4'(i + 1);
      end
    end
    return code;
  endfunction : mfap_dur_code
endpackage : mfap_pkg

/* File: src/mfap_wait_enc.sv */
// encodes a select wait in microseconds to exponent and mantissa
`timescale 1ns/1ps
module mfap_wait_enc (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_wait_us,
  output logic [7:0] o_code
);
  import mfap_pkg::*;
  logic [7:0] code_nxt;
  always_comb begin
    logic found;
    logic [16:0] q;
    found = 1'b0;
    q = 17'h00000;
    code_nxt = WAIT_CODE_MAX;
    for (int e = 0; e < 8; e++) begin
      q = (17'(i_wait_us) + ((17'h00001 << e) - 17'h00001)) >> e;
      if (!found && q <= 17'(MANT_MAX)) begin
        found = 1'b1;
        code_nxt = {3'(e), q[4:0]};
      end
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_code <= RDATA_RST;
    end else begin
      o_code <= code_nxt;
    end
  end
endmodule : mfap_wait_enc
